// ---- common/cal_regs_defines.svh ----
// Register indices, field positions, reset values and bus codes for the calibration register group
`ifndef CAL_REGS_DEFINES_SVH
`define CAL_REGS_DEFINES_SVH

// =====================================================================
// Register indices (byte address is four times the index)
`define IDX_PROGRESS_STATUS  10'h06a
`define IDX_PIN_SETUP        10'h06b
`define IDX_SOFT_TRIGGER     10'h06c
`define IDX_LOWPOWER_SETUP   10'h06e
`define IDX_EVENT_STATUS     10'h070
`define IDX_EVENT_MASK       10'h071
`define ADDR_WIDTH           12

// =====================================================================
// Reset values
`define RST_PIN_SETUP        8'h00
`define RST_SOFT_TRIGGER     8'h01
`define RST_LOWPOWER_SETUP   8'h88
`define RST_EVENT_MASK       3'h0

// =====================================================================
// Field positions
`define FLD_FG_COMPLETE      0
`define FLD_BG_HALTED        1
`define FLD_CODE_LO          2
`define FLD_CODE_HI          4
`define FLD_SRC_SEL          0
`define FLD_PINSEL_LO        1
`define FLD_PINSEL_HI        2
`define FLD_SOFT_TRIG        0
`define FLD_LP_ENABLE        0
`define FLD_TRIG_MODE        1
`define FLD_WAKE_LO          3
`define FLD_WAKE_HI          4
`define FLD_SLEEP_LO         5
`define FLD_SLEEP_HI         7

// =====================================================================
// Event bits and bus responses
`define EVT_FG_COMPLETE      0
`define EVT_BG_HALTED        1
`define EVT_ALARM            2
`define EVT_COUNT            3
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// ---- common/cal_regs_pkg.sv ----
// Types shared by the calibration register group
package cal_regs_pkg;
	// Source mirrored on the status output pin
	typedef enum logic [1:0] {
		STATPIN_FG_COMPLETE,
		STATPIN_BG_HALTED,
		STATPIN_ALARM,
		STATPIN_LOW
	} status_pin_select_t;
endpackage

// ---- src/calibration_status_trigger_regs.sv ----
// Calibration status, trigger selection and low-power setup registers behind an AXI4-Lite slave
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "cal_regs_defines.svh"
`default_nettype none

module calibration_status_trigger_regs (
	input  wire logic                    aclk,                  // 125 MHz clock
	input  wire logic                    aresetn,               // Synchronous reset, active low
	input  wire logic                    s_axi_awvalid,         // Write address valid
	output logic                         s_axi_awready,         // Write address ready
	input  wire logic [`ADDR_WIDTH-1:0]  s_axi_awaddr,          // Write byte address
	input  wire logic                    s_axi_wvalid,          // Write data valid
	output logic                         s_axi_wready,          // Write data ready
	input  wire logic [31:0]             s_axi_wdata,           // Write data
	input  wire logic [3:0]              s_axi_wstrb,           // Byte enables
	output logic                         s_axi_bvalid,          // Write response valid
	input  wire logic                    s_axi_bready,          // Write response ready
	output logic [1:0]                   s_axi_bresp,           // Write response code
	input  wire logic                    s_axi_arvalid,         // Read address valid
	output logic                         s_axi_arready,         // Read address ready
	input  wire logic [`ADDR_WIDTH-1:0]  s_axi_araddr,          // Read byte address
	output logic                         s_axi_rvalid,          // Read data valid
	input  wire logic                    s_axi_rready,          // Read data ready
	output logic [31:0]                  s_axi_rdata,           // Read data
	output logic [1:0]                   s_axi_rresp,           // Read response code
	input  wire logic                    fg_complete_in,        // Engine: foreground done or skipped
	input  wire logic                    bg_halt_event,         // Engine: background halted at phase
	input  wire logic                    bg_resume_event,       // Engine: background running again
	input  wire logic                    background_calibration_enable, // Background calibration on
	input  wire logic [2:0]              progress_code_in,      // Engine: status code
	input  wire logic                    alarm_in,              // Alarm level
	input  wire logic                    trigger_input_pin,     // Asynchronous trigger pin
	output logic                         status_output_pin,     // Selected status flag
	output logic                         calibration_trigger,   // Synchronised trigger to sequencer
	output logic                         lowpower_active,       // Low-power background in force
	output logic                         offline_wake,          // Wake the offline converter
	output logic [2:0]                   idle_sleep_interval,   // Sleep delay code, autonomous mode
	output logic [1:0]                   wake_settle_interval,  // Wake settle delay code
	output logic                         irq                    // Level interrupt
);

	// =====================================================================
	// Register state
	logic [7:0]             pin_setup_reg;
	logic [7:0]             soft_trigger_reg;
	logic [7:0]             lowpower_setup_reg;
	logic                   fg_complete_reg;
	logic                   halted_flag_reg;
	logic [2:0]             status_code_reg;
	logic                   alarm_reg;
	logic [`EVT_COUNT-1:0]  event_status_reg;
	logic [`EVT_COUNT-1:0]  event_mask_reg;
	logic                   pin_meta_reg;
	logic                   pin_sync_reg;
	logic                   trigger_level_reg;

	// =====================================================================
	// Write and read channel state
	logic                   aw_full_reg;
	logic                   w_full_reg;
	logic [`ADDR_WIDTH-1:0] aw_addr_reg;
	logic [7:0]             w_data_reg;
	logic                   w_lane_reg;
	logic                   awready_reg;
	logic                   wready_reg;
	logic                   bvalid_reg;
	logic [1:0]             bresp_reg;
	logic                   arready_reg;
	logic                   rvalid_reg;
	logic [31:0]            rdata_reg;
	logic [1:0]             rresp_reg;

	logic                   aw_take;
	logic                   w_take;
	logic                   ar_take;
	logic                   do_write;
	logic                   aw_full_next;
	logic                   w_full_next;
	logic                   bvalid_next;
	logic                   rvalid_next;
	logic [9:0]             wr_idx;
	logic [9:0]             rd_idx;
	logic                   wr_hit;
	logic [31:0]            rd_value;
	logic                   rd_hit;
	logic [`EVT_COUNT-1:0]  event_set;
	logic [`EVT_COUNT-1:0]  event_clr;
	logic [`EVT_COUNT-1:0]  event_status_next;
	logic                   trigger_src_next;
	cal_regs_pkg::status_pin_select_t pin_select;

	assign aw_take      = s_axi_awvalid & awready_reg;
	assign w_take       = s_axi_wvalid & wready_reg;
	assign ar_take      = s_axi_arvalid & arready_reg;
	// Address and data may arrive in either order; the write happens once both are held
	assign do_write     = aw_full_reg & w_full_reg & ~bvalid_reg;
	assign aw_full_next = (aw_full_reg | aw_take) & ~do_write;
	assign w_full_next  = (w_full_reg | w_take) & ~do_write;
	assign bvalid_next  = do_write | (bvalid_reg & ~s_axi_bready);
	assign rvalid_next  = ar_take | (rvalid_reg & ~s_axi_rready);
	assign wr_idx       = aw_addr_reg[`ADDR_WIDTH-1:2];
	assign rd_idx       = s_axi_araddr[`ADDR_WIDTH-1:2];
	assign pin_select   = cal_regs_pkg::status_pin_select_t'(pin_setup_reg[`FLD_PINSEL_HI:`FLD_PINSEL_LO]);

	// Decode of the write target; read-only status takes writes silently
	always_comb begin
		unique case (wr_idx)
			`IDX_PROGRESS_STATUS, `IDX_PIN_SETUP, `IDX_SOFT_TRIGGER,
			`IDX_LOWPOWER_SETUP, `IDX_EVENT_STATUS, `IDX_EVENT_MASK: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// Read mux; upper bits of every register read as zero
	always_comb begin
		rd_hit   = 1'b1;
		rd_value = 32'h0000_0000;
		unique case (rd_idx)
			`IDX_PROGRESS_STATUS: rd_value = {27'h0000000, status_code_reg, halted_flag_reg, fg_complete_reg};
			`IDX_PIN_SETUP:       rd_value = {24'h000000, pin_setup_reg};
			`IDX_SOFT_TRIGGER:    rd_value = {24'h000000, soft_trigger_reg};
			`IDX_LOWPOWER_SETUP:  rd_value = {24'h000000, lowpower_setup_reg};
			`IDX_EVENT_STATUS:    rd_value = {29'h00000000, event_status_reg};
			`IDX_EVENT_MASK:      rd_value = {29'h00000000, event_mask_reg};
			default:              rd_hit   = 1'b0;
		endcase
	end

	// =====================================================================
	// AXI4-Lite write handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `RESP_OKAY;
			aw_addr_reg <= '0;
			w_data_reg  <= 8'h00;
			w_lane_reg  <= 1'b0;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg  <= w_full_next;
			awready_reg <= ~aw_full_next;
			wready_reg  <= ~w_full_next;
			bvalid_reg  <= bvalid_next;
			if (aw_take) begin
				aw_addr_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				w_data_reg <= s_axi_wdata[7:0];
				w_lane_reg <= s_axi_wstrb[0];
			end
			if (do_write) begin
				bresp_reg <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

	// =====================================================================
	// AXI4-Lite read; one read outstanding, answered the cycle after acceptance
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= `RESP_OKAY;
		end else begin
			arready_reg <= ~rvalid_next;
			rvalid_reg  <= rvalid_next;
			if (ar_take) begin
				rdata_reg <= rd_value;
				rresp_reg <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

	// =====================================================================
	// Writable setup registers; only byte lane 0 carries data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_setup_reg      <= `RST_PIN_SETUP;
			soft_trigger_reg   <= `RST_SOFT_TRIGGER;
			lowpower_setup_reg <= `RST_LOWPOWER_SETUP;
			event_mask_reg     <= `RST_EVENT_MASK;
		end else if (do_write && w_lane_reg) begin
			// Reserved bits are stored as written; software is expected to keep them at default
			unique case (wr_idx)
				`IDX_PIN_SETUP:      pin_setup_reg      <= w_data_reg;
				`IDX_SOFT_TRIGGER:   soft_trigger_reg   <= w_data_reg;
				`IDX_LOWPOWER_SETUP: lowpower_setup_reg <= w_data_reg;
				`IDX_EVENT_MASK:     event_mask_reg     <= w_data_reg[`EVT_COUNT-1:0];
				default: ;
			endcase
		end
	end

	// =====================================================================
	// Calibration flags sampled from the engine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fg_complete_reg <= 1'b0;
			halted_flag_reg <= 1'b0;
			status_code_reg <= 3'h0;
			alarm_reg       <= 1'b0;
		end else begin
			fg_complete_reg <= fg_complete_in;
			status_code_reg <= progress_code_in;
			alarm_reg       <= alarm_in;
			if (!background_calibration_enable) begin
				halted_flag_reg <= fg_complete_in;
			end else if (bg_halt_event) begin
				halted_flag_reg <= 1'b1;
			end else if (bg_resume_event) begin
				halted_flag_reg <= 1'b0;
			end
		end
	end

	// =====================================================================
	// Trigger source; the pin is asynchronous so it passes two flops first
	assign trigger_src_next = pin_setup_reg[`FLD_SRC_SEL] ? pin_sync_reg
		: soft_trigger_reg[`FLD_SOFT_TRIG];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta_reg      <= 1'b1;
			pin_sync_reg      <= 1'b1;
			trigger_level_reg <= 1'b1;
		end else begin
			pin_meta_reg      <= trigger_input_pin;
			pin_sync_reg      <= pin_meta_reg;
			trigger_level_reg <= trigger_src_next;
		end
	end

	// =====================================================================
	// Status pin and low-power controls
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_output_pin    <= 1'b0;
			lowpower_active      <= 1'b0;
			offline_wake         <= 1'b0;
			idle_sleep_interval  <= 3'h4;
			wake_settle_interval <= 2'h1;
		end else begin
			unique case (pin_select)
				cal_regs_pkg::STATPIN_FG_COMPLETE: status_output_pin <= fg_complete_reg;
				cal_regs_pkg::STATPIN_BG_HALTED: status_output_pin <= halted_flag_reg;
				cal_regs_pkg::STATPIN_ALARM:     status_output_pin <= alarm_reg;
				cal_regs_pkg::STATPIN_LOW:       status_output_pin <= 1'b0;
			endcase
			// Low-power mode is meaningless without background calibration, so it is gated here
			lowpower_active <= lowpower_setup_reg[`FLD_LP_ENABLE] & background_calibration_enable;
			offline_wake    <= lowpower_active & lowpower_setup_reg[`FLD_TRIG_MODE]
				& ~trigger_level_reg;
			idle_sleep_interval  <= lowpower_setup_reg[`FLD_SLEEP_HI:`FLD_SLEEP_LO];
			wake_settle_interval <= lowpower_setup_reg[`FLD_WAKE_HI:`FLD_WAKE_LO];
		end
	end

	// =====================================================================
	// Sticky events, write one to clear; a new event beats a clear in the same cycle
	assign event_set = {alarm_in & ~alarm_reg,
		background_calibration_enable & bg_halt_event,
		fg_complete_in & ~fg_complete_reg};
	assign event_clr = (do_write && w_lane_reg && wr_idx == `IDX_EVENT_STATUS)
		? w_data_reg[`EVT_COUNT-1:0] : '0;
	assign event_status_next = (event_status_reg & ~event_clr) | event_set;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			event_status_reg <= '0;
			irq              <= 1'b0;
		end else begin
			event_status_reg <= event_status_next;
			irq              <= |(event_status_next & event_mask_reg);
		end
	end

	assign calibration_trigger = trigger_level_reg;
	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// =====================================================================
	// Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_pin_selected_high;
		trigger_input_pin && pin_setup_reg[0] ##1 pin_setup_reg[0] ##1 pin_setup_reg[0];
	endsequence

	sequence s_status_read;
		ar_take && rd_idx == `IDX_PROGRESS_STATUS;
	endsequence

	a_halt_sets: assert property (background_calibration_enable && bg_halt_event |=> halted_flag_reg)
		else $error("halted flag not set after halt");
	a_resume_clears: assert property (background_calibration_enable && !bg_halt_event && bg_resume_event
		|=> !halted_flag_reg)
		else $error("halted flag not cleared on resume");
	a_halt_follows_fg: assert property (!background_calibration_enable
		|=> halted_flag_reg == $past(fg_complete_in))
		else $error("halted flag does not follow foreground done");
	a_fg_complete_bit: assert property (s_status_read
		|=> s_axi_rvalid && s_axi_rdata[0] == $past(fg_complete_reg))
		else $error("status bit 0 wrong");
	a_status_code: assert property (s_status_read |=> s_axi_rdata[31:5] == 27'h0000000
		&& s_axi_rdata[4:2] == $past(status_code_reg))
		else $error("status code or upper bits wrong");
	a_pin_forced_low: assert property (pin_setup_reg[2:1] == 2'h3 |=> !status_output_pin)
		else $error("status pin not held low");
	a_pin_halted: assert property (pin_setup_reg[2:1] == 2'h1 |=> status_output_pin == $past(halted_flag_reg))
		else $error("status pin not mirroring halted flag");
	a_soft_source: assert property (!pin_setup_reg[0] |=> calibration_trigger == $past(soft_trigger_reg[0]))
		else $error("software trigger not used");
	a_pin_source: assert property (s_pin_selected_high |=> calibration_trigger)
		else $error("synchronised pin trigger not seen");
	a_reset_values: assert property (disable iff (1'b0) !aresetn
		|=> soft_trigger_reg == 8'h01 && lowpower_setup_reg == 8'h88)
		else $error("setup registers reset wrong");
	a_lp_gated: assert property (!background_calibration_enable |=> !lowpower_active)
		else $error("low-power active without background");
	a_trig_wake: assert property (lowpower_active && lowpower_setup_reg[1] && !trigger_level_reg
		|=> offline_wake)
		else $error("offline converter not woken by low trigger");

endmodule

`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the calibration status and trigger register group
`timescale 1ns/1ps
`include "cal_regs_defines.svh"
`default_nettype none

module tb_top;
	// ===================================================================
	// Signals and reference model state
	logic             aclk = 1'b0;
	logic             aresetn = 1'b0;
	logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [11:0]      awaddr = 12'h000, araddr = 12'h000;
	logic [31:0]      wdata = 32'h0;
	logic             fg_complete = 1'b0, halt_ev = 1'b0, resume_ev = 1'b0, bg_en = 1'b0, alarm = 1'b0;
	logic [2:0]       code = 3'h0;
	logic             trig_req = 1'b1;
	wire logic        awready, wready, bvalid, arready, rvalid, trig_pin, stat_pin, stat_seen;
	wire logic        cal_trig, lp_act, off_wake, irq;
	wire logic [1:0]  bresp, rresp, wake_int;
	wire logic [2:0]  sleep_int;
	wire logic [31:0] rdata;
	logic [31:0]      rng = 32'd75259;
	logic [31:0]      r;
	logic [2:0]       ev = 3'h0, mask = 3'h0;
	logic             halted = 1'b0;
	int               failures = 0, tests_run = 0;

	calibration_status_trigger_regs u_calibration_status_trigger_regs (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.fg_complete_in(fg_complete), .bg_halt_event(halt_ev), .bg_resume_event(resume_ev),
		.background_calibration_enable(bg_en), .progress_code_in(code), .alarm_in(alarm),
		.trigger_input_pin(trig_pin), .status_output_pin(stat_pin), .calibration_trigger(cal_trig),
		.lowpower_active(lp_act), .offline_wake(off_wake), .idle_sleep_interval(sleep_int),
		.wake_settle_interval(wake_int), .irq(irq)
	);

	trigger_host_model u_trigger_host_model (
		.aclk(aclk), .trigger_request(trig_req), .trigger_input_pin(trig_pin),
		.status_output_pin(stat_pin), .status_seen(stat_seen)
	);

	// Free-running 125 MHz clock
	initial begin
		forever #4 aclk = ~aclk;
	end

	// ===================================================================
	// Helpers
	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	// Write master: address and data offered together, bready held until the response
	task automatic axw(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er);
		awaddr <= {idx, 2'b00};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(bresp, er);
		@(posedge aclk);
	endtask

	// Read master: one read at a time, data taken at the edge that sees rvalid
	task automatic axr(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, exp);
		chk(rresp, er);
		@(posedge aclk);
	endtask

	// Engine inputs change, model tracks rising-edge events, then status is read back
	task automatic flags(input logic f, input logic a, input logic b, input logic [2:0] c);
		if (f && !fg_complete) ev = ev | 3'h1;
		if (a && !alarm) ev = ev | 3'h4;
		// With background off the halted flag tracks foreground done, and keeps it when switched on
		if (!b) halted = f;
		fg_complete <= f;
		alarm <= a;
		bg_en <= b;
		code <= c;
		repeat (3) @(posedge aclk);
		axr(`IDX_PROGRESS_STATUS, {c, (b ? halted : f), f}, `RESP_OKAY);
	endtask

	// One-cycle halt or resume pulse from the engine
	task automatic pulse(input logic h);
		halt_ev <= h;
		resume_ev <= ~h;
		@(posedge aclk);
		halt_ev <= 1'b0;
		resume_ev <= 1'b0;
		if (h) ev = ev | 3'h2;
		halted = h;
	endtask

	// Expected level on the status pin for a select code
	function automatic logic pin_exp(input int s);
		case (s)
			0: return fg_complete;
			1: return halted;
			2: return alarm;
			default: return 1'b0;
		endcase
	endfunction

	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Watchdog: the whole sequence needs well under 3,000 cycles
	initial begin
		#(8 * 20000);
		failures++;
		end_sim();
	end

	// ===================================================================
	// Main sequence
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		// Reset state of outputs and registers
		chk({lp_act, off_wake, irq, stat_pin, cal_trig}, 5'b00001);
		chk({sleep_int, wake_int}, 5'b10001);
		axr(`IDX_PROGRESS_STATUS, 32'h0, `RESP_OKAY);
		axr(`IDX_PIN_SETUP, `RST_PIN_SETUP, `RESP_OKAY);
		axr(`IDX_SOFT_TRIGGER, `RST_SOFT_TRIGGER, `RESP_OKAY);
		axr(`IDX_LOWPOWER_SETUP, `RST_LOWPOWER_SETUP, `RESP_OKAY);
		axr(`IDX_EVENT_MASK, 32'h0, `RESP_OKAY);
		// Unmapped place and read-only status register
		axw(10'h040, 32'hff, `RESP_SLVERR);
		axr(10'h040, 32'h0, `RESP_SLVERR);
		axw(`IDX_PROGRESS_STATUS, 32'h1f, `RESP_OKAY);
		// Foreground flag, then halt and resume with background running
		for (int i = 0; i < 3; i++) begin
			r = xs();
			flags(i[0] ^ 1'b1, 1'b0, 1'b0, r[2:0]);
		end
		flags(1'b1, 1'b0, 1'b1, 3'h5);
		pulse(1'b1);
		flags(1'b0, 1'b0, 1'b1, 3'h2);
		pulse(1'b0);
		flags(1'b1, 1'b0, 1'b1, 3'h7);
		pulse(1'b1);
		// Every status pin select against differing flag levels
		for (int s = 0; s < 4; s++) begin
			axw(`IDX_PIN_SETUP, {29'h0, s[1:0], 1'b0}, `RESP_OKAY);
			for (int v = 0; v < 2; v++) begin
				flags(v[0], ~v[0], 1'b1, 3'h0);
				repeat (2) @(posedge aclk);
				chk(stat_seen, pin_exp(s));
			end
		end
		// Trigger source, pin and software bit in all combinations, with trigger-driven low power
		r = xs();
		axw(`IDX_LOWPOWER_SETUP, {24'h0, r[7:3], 3'b011}, `RESP_OKAY);
		for (int k = 0; k < 8; k++) begin
			axw(`IDX_PIN_SETUP, {31'h0, k[2]}, `RESP_OKAY);
			axw(`IDX_SOFT_TRIGGER, {31'h0, k[0]}, `RESP_OKAY);
			trig_req <= k[1];
			repeat (6) @(posedge aclk);
			chk(cal_trig, k[2] ? k[1] : k[0]);
			chk({lp_act, off_wake}, {1'b1, ~(k[2] ? k[1] : k[0])});
			chk({sleep_int, wake_int}, r[7:3]);
		end
		axr(`IDX_LOWPOWER_SETUP, {24'h0, r[7:3], 3'b011}, `RESP_OKAY);
		bg_en <= 1'b0;
		repeat (3) @(posedge aclk);
		chk({lp_act, off_wake}, 2'b00);
		axw(`IDX_SOFT_TRIGGER, 32'h1, `RESP_OKAY);
		// Sticky events, mask and write-one clear
		axr(`IDX_EVENT_STATUS, ev, `RESP_OKAY);
		axw(`IDX_EVENT_MASK, 32'h7, `RESP_OKAY);
		mask = 3'h7;
		repeat (2) @(posedge aclk);
		chk(irq, |(ev & mask));
		axw(`IDX_EVENT_STATUS, 32'h7, `RESP_OKAY);
		ev = 3'h0;
		axr(`IDX_EVENT_STATUS, 32'h0, `RESP_OKAY);
		chk(irq, 1'b0);
		axw(`IDX_EVENT_MASK, 32'h1, `RESP_OKAY);
		bg_en <= 1'b1;
		pulse(1'b1);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b0);
		axw(`IDX_EVENT_MASK, 32'h2, `RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b1);
		axw(`IDX_EVENT_STATUS, 32'h2, `RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b0);
		// Reset in mid-run brings written setup registers back to their defaults
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk({sleep_int, wake_int}, 5'b10001);
		axr(`IDX_LOWPOWER_SETUP, `RST_LOWPOWER_SETUP, `RESP_OKAY);
		axr(`IDX_SOFT_TRIGGER, `RST_SOFT_TRIGGER, `RESP_OKAY);
		axr(`IDX_PIN_SETUP, `RST_PIN_SETUP, `RESP_OKAY);
		end_sim();
	end
endmodule
`default_nettype wire

// ---- testbench/trigger_host_model.sv ----
// Behavioural system controller that drives the trigger pin and watches the status pin
`timescale 1ns/1ps
`default_nettype none

module trigger_host_model (
	input  wire logic aclk,              // Device clock, used only to sample the status pin
	input  wire logic trigger_request,   // Level the controller wants on the trigger pin
	output logic      trigger_input_pin, // Trigger pin into the device
	input  wire logic status_output_pin, // Status pin from the device
	output logic      status_seen        // Status pin as sampled by the controller
);
	// ===================================================================
	// Trigger pin
	// Follows the request, which idles high, so no trigger is asserted until one is asked for
	// Moves 3 ns after the request, off the clock edge, so the synchroniser sees a truly async pin
	assign #3 trigger_input_pin = trigger_request;

	// ===================================================================
	// Status pin monitor
	always @(posedge aclk) begin
		status_seen <= status_output_pin;
	end
endmodule
`default_nettype wire
